//--- fpes_map.svh
// constants for the program/erase status block
`ifndef FPES_MAP_SVH
`define FPES_MAP_SVH
`define FPES_BIT_IDLE     3'd7
`define FPES_BIT_EPAUSE   3'd6
`define FPES_BIT_EFAIL    3'd5
`define FPES_BIT_PFAIL    3'd4
`define FPES_BIT_SUPPLY   3'd3
`define FPES_BIT_PPAUSE   3'd2
`define FPES_BIT_PROTECT  3'd1
`define FPES_BIT_RSVD     3'd0
`define FPES_STATUS_RESET 8'h80
`define FPES_CMD_STATUS   8'h70
`define FPES_CMD_CLEAR    8'h50
`define FPES_CMD_SUSPEND  8'hb0
`define FPES_CMD_RESUME   8'hd0
`define FPES_CMD_PROG_A   8'h40
`define FPES_CMD_PROG_B   8'h10
`define FPES_CMD_PROG_Q   8'h30
`define FPES_CMD_ERASE_C  8'h80
`define FPES_CMD_ERASE_B  8'h20
`define FPES_CMD_ERASE_S  8'h32
`define FPES_CMD_READ     8'hff
`define FPES_MAX_PULSES   16
`define FPES_PULSE_CYCLES 4
`endif

//--- fpes_pkg.sv
// types for the program/erase status block
package fpes_pkg;
	typedef enum logic [2:0] {
		FPES_IDLE    = 3'b000,
		FPES_PULSE   = 3'b001,
		FPES_VERIFY  = 3'b011,
		FPES_PAUSING = 3'b010,
		FPES_PAUSED  = 3'b110
	} fpes_state_e;
	typedef enum logic [1:0] {
		FPES_OP_NONE  = 2'b00,
		FPES_OP_PROG  = 2'b01,
		FPES_OP_ERASE = 2'b10
	} fpes_op_e;
	typedef logic [7:0] fpes_byte_t;
endpackage : fpes_pkg

//--- fpes_if.sv
// read-mode select between command decode and the read path
`timescale 1ns/1ps
interface fpes_rd_if;
	logic       show_status;
	logic [7:0] status;
	modport dec (output show_status, input status);
	modport rd  (input show_status, input status);
endinterface : fpes_rd_if

//--- fpes_read_mux.sv
// read data path: status byte or array data
`timescale 1ns/1ps
module fpes_read_mux (
	input  wire logic         clk,
	input  wire logic         reset_n,
	fpes_rd_if.rd             sel,
	input  wire logic [7:0]   array_data,
	output logic      [7:0]   read_data
);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			read_data <= 8'h00;
		end else begin
			// any address gives status in status mode
			read_data <= sel.show_status ? sel.status : array_data;
		end
	end
endmodule : fpes_read_mux

//--- fpes_status.sv
// program/erase engine status logic with command decode
`timescale 1ns/1ps
`include "fpes_map.svh"
module fpes_status #(
	parameter int MAX_PULSES   = `FPES_MAX_PULSES,
	parameter int PULSE_CYCLES = `FPES_PULSE_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              cmd_valid,
	input  wire logic [7:0]        cmd_data,
	input  wire logic              mux_mode,
	input  wire logic              supply_ok,
	input  wire logic              target_protected,
	input  wire logic              finish_on_suspend,
	input  wire logic              verify_pass,
	input  wire logic [7:0]        array_data,
	output logic      [7:0]        read_data,
	output fpes_pkg::fpes_byte_t   program_erase_status,
	output logic                   engine_busy
);
	import fpes_pkg::*;

	fpes_state_e state_q;
	fpes_op_e    op_q;
	logic        erase_paused_flag_q;
	logic        program_paused_flag_q;
	logic        erase_fail_flag_q;
	logic        program_fail_flag_q;
	logic        supply_fault_flag_q;
	logic        protect_violation_flag_q;
	logic        second_q;
	logic [7:0]  first_q;
	logic        show_status_q;
	logic        nested_prog_q;
	logic [15:0] pulses_q;
	logic [15:0] tick_q;
	logic        start_prog;
	logic        start_erase;
	logic        is_suspend;
	logic        is_resume;
	logic        is_clear;
	logic        start_op;
	logic        start_bad;
	logic        op_fail;
	logic        suspend_now;
	fpes_rd_if   rd_sel ();

	function automatic logic cmd_is_prog(input logic [7:0] c);
		return c == `FPES_CMD_PROG_A || c == `FPES_CMD_PROG_B || c == `FPES_CMD_PROG_Q;
	endfunction : cmd_is_prog

	function automatic logic cmd_is_erase_setup(input logic [7:0] c);
		return c == `FPES_CMD_ERASE_C || c == `FPES_CMD_ERASE_B || c == `FPES_CMD_ERASE_S;
	endfunction : cmd_is_erase_setup

	// two-cycle commands: first cycle is setup, second starts the engine
	always_comb begin
		start_prog  = cmd_valid && second_q && cmd_is_prog(first_q);
		start_erase = cmd_valid && second_q && cmd_is_erase_setup(first_q);
		is_suspend  = cmd_valid && !second_q && cmd_data == `FPES_CMD_SUSPEND;
		is_resume   = cmd_valid && !second_q && cmd_data == `FPES_CMD_RESUME;
		is_clear    = cmd_valid && !second_q && cmd_data == `FPES_CMD_CLEAR;
		// program accepted in idle or during erase suspend only
		start_op    = (start_prog && (state_q == FPES_IDLE ||
			(state_q == FPES_PAUSED && op_q == FPES_OP_ERASE))) ||
			(start_erase && state_q == FPES_IDLE);
		// supply sampled only here, at the start
		start_bad   = !supply_ok || target_protected;
		op_fail     = pulses_q >= 16'(MAX_PULSES - 1) && !verify_pass;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			second_q <= 1'b0;
			first_q  <= 8'h00;
		end else if (cmd_valid) begin
			second_q <= !second_q && (cmd_is_prog(cmd_data) || cmd_is_erase_setup(cmd_data));
			first_q  <= cmd_data;
		end
	end

	// read mode selection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			show_status_q <= 1'b0;
		end else if (cmd_valid) begin
			if (second_q) begin
				show_status_q <= 1'b1;
			end else if (cmd_data == `FPES_CMD_STATUS || cmd_data == `FPES_CMD_RESUME) begin
				show_status_q <= 1'b1;
			end else if (cmd_data == `FPES_CMD_READ) begin
				show_status_q <= 1'b0;
			end
		end
	end

	// suspend can cut a pulse short; engine may just finish instead
	assign suspend_now = finish_on_suspend ? 1'b0 : 1'b1;

	// engine sequencing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q       <= FPES_IDLE;
			op_q          <= FPES_OP_NONE;
			nested_prog_q <= 1'b0;
			pulses_q      <= 16'h0000;
			tick_q        <= 16'h0000;
		end else begin
			case (state_q)
				FPES_IDLE, FPES_PAUSED: begin
					if (start_op && !start_bad) begin
						nested_prog_q <= state_q == FPES_PAUSED;
						if (state_q == FPES_IDLE) begin
							op_q <= start_prog ? FPES_OP_PROG : FPES_OP_ERASE;
						end
						state_q  <= FPES_PULSE;
						pulses_q <= 16'h0000;
						tick_q   <= 16'h0000;
					end else if (state_q == FPES_PAUSED && is_resume) begin
						state_q <= FPES_PULSE;
						tick_q  <= 16'h0000;
					end
				end
				FPES_PULSE: begin
					if (tick_q >= 16'(PULSE_CYCLES - 1)) begin
						state_q <= FPES_VERIFY;
					end else begin
						tick_q <= tick_q + 16'h0001;
					end
				end
				FPES_VERIFY, FPES_PAUSING: begin
					tick_q <= 16'h0000;
					if (verify_pass || op_fail) begin
						// nested program returns to the suspended erase
						state_q       <= nested_prog_q ? FPES_PAUSED : FPES_IDLE;
						nested_prog_q <= 1'b0;
						if (!nested_prog_q) begin
							op_q <= FPES_OP_NONE;
						end
					end else if (state_q == FPES_PAUSING) begin
						state_q <= FPES_PAUSED;
					end else begin
						pulses_q <= pulses_q + 16'h0001;
						state_q  <= FPES_PULSE;
					end
				end
				default: begin
					state_q <= FPES_IDLE;
				end
			endcase
			// suspend leaves pulse or verify for pausing on the next edge, without waiting for the pulse to end
			if (is_suspend && suspend_now && !nested_prog_q &&
				(state_q == FPES_PULSE || state_q == FPES_VERIFY)) begin
				state_q <= FPES_PAUSING;
			end
		end
	end

	// suspend flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			erase_paused_flag_q   <= 1'b0;
			program_paused_flag_q <= 1'b0;
		end else if (state_q == FPES_PAUSED && is_resume) begin
			erase_paused_flag_q   <= 1'b0;
			program_paused_flag_q <= 1'b0;
		end else if (state_q == FPES_PAUSING && !(verify_pass || op_fail)) begin
			erase_paused_flag_q   <= op_q == FPES_OP_ERASE;
			program_paused_flag_q <= op_q == FPES_OP_PROG;
		end
	end

	// sticky error flags; a new fault wins over a same-cycle clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			erase_fail_flag_q        <= 1'b0;
			program_fail_flag_q      <= 1'b0;
			supply_fault_flag_q      <= 1'b0;
			protect_violation_flag_q <= 1'b0;
		end else begin
			if (is_clear) begin
				erase_fail_flag_q        <= 1'b0;
				program_fail_flag_q      <= 1'b0;
				supply_fault_flag_q      <= 1'b0;
				protect_violation_flag_q <= 1'b0;
			end
			if (start_op && !supply_ok) begin
				supply_fault_flag_q <= 1'b1;
			end
			if (start_op && supply_ok && target_protected) begin
				protect_violation_flag_q <= 1'b1;
			end
			if (start_op && start_bad) begin
				erase_fail_flag_q   <= erase_fail_flag_q | start_erase;
				program_fail_flag_q <= program_fail_flag_q | start_prog;
			end
			if ((state_q == FPES_VERIFY || state_q == FPES_PAUSING) && op_fail) begin
				if (nested_prog_q || op_q == FPES_OP_PROG) begin
					program_fail_flag_q <= 1'b1;
				end else begin
					erase_fail_flag_q <= 1'b1;
				end
			end
		end
	end

	// status byte assembly; success sets none of the low bits, sticky flags from earlier faults stay set
	always_comb begin
		program_erase_status = 8'h00;
		program_erase_status[`FPES_BIT_IDLE] =
			state_q == FPES_IDLE || state_q == FPES_PAUSED;
		program_erase_status[`FPES_BIT_EPAUSE] = erase_paused_flag_q ||
			(nested_prog_q && state_q != FPES_IDLE);
		program_erase_status[`FPES_BIT_EFAIL]   = erase_fail_flag_q;
		program_erase_status[`FPES_BIT_PFAIL]   = program_fail_flag_q;
		program_erase_status[`FPES_BIT_SUPPLY]  = supply_fault_flag_q;
		program_erase_status[`FPES_BIT_PPAUSE]  = program_paused_flag_q;
		// programmer interface never reports protection
		program_erase_status[`FPES_BIT_PROTECT] = protect_violation_flag_q && !mux_mode;
		program_erase_status[`FPES_BIT_RSVD]    = 1'b0;
		engine_busy = !program_erase_status[`FPES_BIT_IDLE];
	end

	assign rd_sel.show_status = show_status_q;
	assign rd_sel.status      = program_erase_status;

	fpes_read_mux u_read_mux (
		.clk        (clk),
		.reset_n    (reset_n),
		.sel        (rd_sel),
		.array_data (array_data),
		.read_data  (read_data)
	);
endmodule : fpes_status

//--- fpes_status_properties.sv
// concurrent checks on the status block's ports
`timescale 1ns/1ps
module fpes_status_properties (
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire logic                 cmd_valid,
	input wire logic [7:0]           cmd_data,
	input wire logic                 mux_mode,
	input wire logic                 supply_ok,
	input wire logic                 target_protected,
	input wire fpes_pkg::fpes_byte_t program_erase_status
);
	import fpes_pkg::*;
	fpes_byte_t st;
	assign st = program_erase_status;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_setup;
		cmd_valid && cmd_data == 8'h40 && st[7] ##1 !cmd_valid;
	endsequence
	sequence s_go_ok;
		cmd_valid && supply_ok && !target_protected;
	endsequence
	property p_start; s_setup ##1 s_go_ok |=> !st[7]; endproperty
	a_start: assert property (p_start) else $error("not busy after start");
	property p_supply; s_setup ##1 (cmd_valid && !supply_ok) |=> st[3] && st[4] && st[7]; endproperty
	a_supply: assert property (p_supply) else $error("supply fault missed");
	property p_rsvd; st[0] == 1'b0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_mux; mux_mode && $past(mux_mode) |-> !st[1]; endproperty
	a_mux: assert property (p_mux) else $error("protect bit seen in mux mode");
	// only a clear command may drop an error flag
	// protect bit may vanish when the programmer interface is selected
	property p_sticky; ($past(st) & ~st & (mux_mode ? 8'h38 : 8'h3a)) != 8'h00 |->
		$past(cmd_valid && cmd_data == 8'h50); endproperty
	a_sticky: assert property (p_sticky) else $error("error flag dropped");
	property p_ppause; st[2] |-> st[7] && !st[6]; endproperty
	a_ppause: assert property (p_ppause) else $error("program pause while running");
	property p_resume; cmd_valid && cmd_data == 8'hd0 && st[7] && (st[6] || st[2]) |=> (st & 8'hc4) == 8'h00; endproperty
	a_resume: assert property (p_resume) else $error("resume left pause flag");
	property p_pair; $rose(st[3]) || $rose(st[1]) |-> st[5] || st[4]; endproperty
	a_pair: assert property (p_pair) else $error("fault without fail flag");
endmodule : fpes_status_properties

bind fpes_status fpes_status_properties u_fpes_status_properties (.clk(clk), .reset_n(reset_n),
	.cmd_valid(cmd_valid), .cmd_data(cmd_data), .mux_mode(mux_mode), .supply_ok(supply_ok),
	.target_protected(target_protected), .program_erase_status(program_erase_status));

//--- fpes_host.sv
// host and array stand-in facing the status block
`timescale 1ns/1ps
module fpes_host (
	input  wire logic                 clk,
	input  wire fpes_pkg::fpes_byte_t program_erase_status,
	output logic                      cmd_valid,
	output fpes_pkg::fpes_byte_t      cmd_data,
	output fpes_pkg::fpes_byte_t      array_data
);
	import fpes_pkg::*;
	initial begin
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
	end
	// array never holds still, so a stale read path shows up
	initial begin
		array_data = 8'h00;
		forever @(negedge clk) array_data <= array_data + 8'h01;
	end
	task automatic wr(input fpes_byte_t d);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_data = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_data = ~d;
	endtask : wr
	task automatic poll(output fpes_byte_t s);
		int n;
		n = 0;
		s = 8'h00;
		while (s[7] !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			s = program_erase_status & 8'hfe;
			n++;
		end
		@(negedge clk);
	endtask : poll
endmodule : fpes_host

//--- tb_flash_program_erase_status.sv
// bench for the program/erase status block
`timescale 1ns/1ps
module tb_flash_program_erase_status;
	import fpes_pkg::*;
	logic       clk;
	logic       reset_n;
	logic       mux_mode;
	logic       supply_ok;
	logic       target_protected;
	logic       finish_on_suspend;
	logic       verify_pass;
	logic       cmd_valid;
	fpes_byte_t cmd_data;
	fpes_byte_t array_data;
	fpes_byte_t read_data;
	fpes_byte_t program_erase_status;
	logic       engine_busy;
	int         n_fail;
	int         compares;
	fpes_host u_fpes_host (.clk(clk), .program_erase_status(program_erase_status),
		.cmd_valid(cmd_valid), .cmd_data(cmd_data), .array_data(array_data));
	// short counts keep the run brief
	fpes_status #(.MAX_PULSES(4), .PULSE_CYCLES(2)) u_fpes_status (.clk(clk),
		.reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .mux_mode(mux_mode),
		.supply_ok(supply_ok), .target_protected(target_protected),
		.finish_on_suspend(finish_on_suspend), .verify_pass(verify_pass),
		.array_data(array_data), .read_data(read_data),
		.program_erase_status(program_erase_status), .engine_busy(engine_busy));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input fpes_byte_t got, input fpes_byte_t exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_busy(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: busy %b expected %b", $time, got, exp);
		end
	endtask : chk_busy
	task automatic wr(input fpes_byte_t d);
		u_fpes_host.wr(d);
	endtask : wr
	task automatic st(input fpes_byte_t exp);
		@(posedge clk);
		#1;
		chk(program_erase_status, exp);
	endtask : st
	task automatic pl(input fpes_byte_t exp);
		fpes_byte_t s;
		u_fpes_host.poll(s);
		chk(s, exp);
	endtask : pl
	task automatic go(input fpes_byte_t c, input fpes_byte_t d, input fpes_byte_t exp);
		wr(c);
		wr(d);
		pl(exp);
	endtask : go
	initial begin
		#100000;
		n_fail++;
		test_done;
	end
	initial begin
		n_fail = 0;
		compares = 0;
		reset_n = 1'b0;
		mux_mode = 1'b0;
		supply_ok = 1'b1;
		target_protected = 1'b0;
		finish_on_suspend = 1'b0;
		verify_pass = 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk) reset_n = 1'b1;
		chk(program_erase_status, 8'h80);
		chk_busy(engine_busy, 1'b0);
		wr(8'h40);
		wr(8'h00);
		st(8'h00);
		chk_busy(engine_busy, 1'b1);
		pl(8'h80);
		@(negedge clk);
		chk(read_data, 8'h80);
		wr(8'hff);
		st(8'h80);
		chk(read_data, array_data);
		wr(8'h70);
		st(8'h80);
		chk(read_data, 8'h80);
		@(negedge clk) verify_pass = 1'b0;
		go(8'h10, 8'h00, 8'h90);
		go(8'h20, 8'hd0, 8'hb0);
		verify_pass = 1'b1;
		go(8'h30, 8'h00, 8'hb0);
		wr(8'h50);
		st(8'h80);
		go(8'h80, 8'hd0, 8'h80);
		@(negedge clk) supply_ok = 1'b0;
		go(8'h40, 8'h00, 8'h98);
		go(8'h32, 8'hd0, 8'hb8);
		wr(8'h50);
		supply_ok = 1'b1;
		wr(8'h20);
		wr(8'hd0);
		supply_ok = 1'b0;
		pl(8'h80);
		supply_ok = 1'b1;
		target_protected = 1'b1;
		go(8'h40, 8'h00, 8'h92);
		wr(8'h50);
		go(8'h20, 8'hd0, 8'ha2);
		wr(8'h50);
		mux_mode = 1'b1;
		go(8'h40, 8'h00, 8'h90);
		wr(8'h50);
		mux_mode = 1'b0;
		target_protected = 1'b0;
		verify_pass = 1'b0;
		wr(8'h20);
		wr(8'hd0);
		wr(8'hb0);
		pl(8'hc0);
		verify_pass = 1'b1;
		wr(8'h40);
		wr(8'h00);
		st(8'h40);
		pl(8'hc0);
		wr(8'hd0);
		st(8'h00);
		pl(8'h80);
		verify_pass = 1'b0;
		wr(8'h40);
		wr(8'h00);
		wr(8'hb0);
		pl(8'h84);
		verify_pass = 1'b1;
		wr(8'hd0);
		st(8'h00);
		pl(8'h80);
		finish_on_suspend = 1'b1;
		verify_pass = 1'b0;
		wr(8'h40);
		wr(8'h00);
		wr(8'hb0);
		pl(8'h90);
		@(negedge clk) reset_n = 1'b0;
		@(negedge clk) reset_n = 1'b1;
		chk(program_erase_status, 8'h80);
		chk(read_data, 8'h00);
		chk_busy(engine_busy, 1'b0);
		test_done;
	end
endmodule : tb_flash_program_erase_status
